// ---- pkg/csc_pkg.sv ----
// Constants and types shared by the clock and sleep controller
// What this block does
// RULE1: Reset leaves only the 2 MHz oscillator enabled; system runs from 2 MHz oscillator.
// RULE2: Software may change clock source and prescaler at any time, safely.
// RULE3: Monitored crystal or PLL failure raises NMI and falls back to internal oscillator.
// RULE4: Ultra low power oscillator runs only while used; divided down to 1 kHz.
// RULE5: 32.768 kHz oscillator gives 1.024 kHz tick too; trim value is writable.
// RULE6: PLL multiplies by a software factor from 1 to 31.
// RULE7: Prescaler divides source by 1 up to 2048.
// RULE8: Fast peripheral ticks run at two and four times the CPU rate, capped at the source rate.
// RULE9: Crystal oscillator offers four selectable frequency band modes.
// RULE10: Power reduction bit stops a peripheral clock, freezing its state.
// RULE11: Wake by interrupt runs its handler, then resumes after the sleep instruction.
// RULE12: Higher priority pending interrupts are served first after wake-up.
// RULE13: CPU stays halted four clock cycles after every wake-up.
// RULE14: State kept in sleep; reset during sleep restarts the device normally.
// RULE15: Idle stops CPU and memory clocks after programming ends; peripherals keep running.
// RULE16: Idle wakes on any enabled interrupt.
// RULE17: Power-down stops all clocks, real-time counter included.
// RULE18: Power-down wakes only on address match or asynchronous port interrupts.
// RULE19: Power-save is power-down plus running real-time counter and its wake-up.
// RULE20: Standby is power-down with enabled oscillators kept running.
// RULE21: Extended standby is power-save with enabled oscillators kept running.
// RULE22: Switch source only once it is ready, without glitches or runt pulses.
package csc_pkg;
	// ------------------------------------------------
	// Clock sources
	// ------------------------------------------------
	localparam int         NSRC      = 6;
	localparam logic [2:0] SRC_RC2M  = 3'h0;
	localparam logic [2:0] SRC_RC32M = 3'h1;
	localparam logic [2:0] SRC_RC32K = 3'h2;
	localparam logic [2:0] SRC_XOSC  = 3'h3;
	localparam logic [2:0] SRC_PLL   = 3'h4;
	localparam logic [2:0] SRC_ULP   = 3'h5;
	localparam int         NFAIL     = 2;
	localparam int         SYNC_W    = 2 * NSRC + NFAIL;
	// ------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------
	localparam int         ADR_W     = 8;
	localparam logic [7:0] A_SRCSEL  = 8'h00;
	localparam logic [7:0] A_PRESC   = 8'h04;
	localparam logic [7:0] A_OSCEN   = 8'h08;
	localparam logic [7:0] A_PLL     = 8'h0c;
	localparam logic [7:0] A_XOSC    = 8'h10;
	localparam logic [7:0] A_CAL32K  = 8'h14;
	localparam logic [7:0] A_FAILMON = 8'h18;
	localparam logic [7:0] A_SLEEP   = 8'h1c;
	localparam logic [7:0] A_PR      = 8'h20;
	localparam logic [7:0] A_STATUS  = 8'h24;
	localparam logic [7:0] A_RTC     = 8'h28;
	// ------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------
	localparam int         PRESC_W   = 4;
	localparam logic [3:0] PRESC_MAX = 4'hb;
	localparam int         CNT_W     = 11;
	localparam int         PLL_W     = 5;
	localparam logic [4:0] PLL_MIN   = 5'h01;
	localparam logic [5:0] RST_OSCEN = 6'h01;
	localparam int         CAL_W     = 8;
	localparam logic [7:0] RST_CAL   = 8'h80;
	localparam int         FM_EN_B   = 0;
	localparam int         FM_FLAG_B = 1;
	localparam int         RTC_EN_B  = 0;
	localparam int         RTC_ULP_B = 1;
	localparam int         SLP_EN_B  = 3;
	localparam int         ST_SLP_B  = 6;
	localparam int         ST_PEND_B = 7;
	// ------------------------------------------------
	// Sleep modes, timing
	// ------------------------------------------------
	localparam logic [2:0] SLP_IDLE   = 3'h0;
	localparam logic [2:0] SLP_PDOWN  = 3'h2;
	localparam logic [2:0] SLP_PSAVE  = 3'h3;
	localparam logic [2:0] SLP_STDBY  = 3'h6;
	localparam logic [2:0] SLP_ESTDBY = 3'h7;
	localparam int         LF_W       = 5;
	localparam logic [4:0] LF_LAST    = 5'h1f;
	localparam logic [1:0] HALT_LAST  = 2'h3;

	typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_SLEEP, ST_HALT} csc_state_t;
endpackage

// ---- pkg/csc_presc_if.sv ----
// Link between the controller and its prescaler chain
`timescale 1ns/1ps
interface csc_presc_if;
	import csc_pkg::*;
	logic               src_tick;
	logic               clr;
	logic [PRESC_W-1:0] div_log2;
	logic               tick1;
	logic               tick2;
	logic               tick4;
	modport ctl (output src_tick, clr, div_log2, input tick1, tick2, tick4);
	modport div (input src_tick, clr, div_log2, output tick1, tick2, tick4);
endinterface

// ---- src/csc_prescaler.sv ----
// Prescaler chain making CPU rate and fast peripheral ticks
`timescale 1ns/1ps
module csc_prescaler
	import csc_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Controller side
	csc_presc_if.div  p
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] m1;
	logic [CNT_W-1:0] m2;
	logic [CNT_W-1:0] m4;

	function automatic logic [CNT_W-1:0] mask(input logic [PRESC_W-1:0] s);
		mask = CNT_W'((1 << s) - 1);
	endfunction

	assign m1 = mask(p.div_log2);
	assign m2 = m1 >> 1;
	assign m4 = m1 >> 2;

	always_ff @(posedge clk_i) begin
		if (rst_i || p.clr) begin
			cnt_reg <= '0;
		end else if (p.src_tick) begin
			cnt_reg <= cnt_reg + 1'b1; // [RULE7]
		end
	end

	// Faster ticks share the counter, so they stay phase locked to tick1
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			p.tick1 <= 1'b0;
			p.tick2 <= 1'b0;
			p.tick4 <= 1'b0;
		end else begin
			p.tick1 <= p.src_tick && (cnt_reg & m1) == '0; // [RULE7]
			p.tick2 <= p.src_tick && (cnt_reg & m2) == '0; // [RULE8]
			p.tick4 <= p.src_tick && (cnt_reg & m4) == '0; // [RULE8]
		end
	end
endmodule // csc_prescaler

// ---- src/csc_top.sv ----
// Clock source selection, prescaling, gating and sleep sequencing
`timescale 1ns/1ps
module csc_top
	import csc_pkg::*;
#(
	parameter int PR_W = 8
) (
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// Wishbone slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [csc_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	// Oscillator pins
	input  wire logic [csc_pkg::NSRC-1:0]  src_clk_i,
	input  wire logic [csc_pkg::NSRC-1:0]  osc_rdy_i,
	input  wire logic [csc_pkg::NFAIL-1:0] osc_fail_i,
	// CPU and interrupt controller
	input  wire logic                   sleep_instr_i,
	input  wire logic                   nvm_busy_i,
	input  wire logic                   irq_pend_i,
	input  wire logic                   twi_match_i,
	input  wire logic                   port_async_i,
	input  wire logic                   rtc_irq_i,
	input  wire logic                   wdt_ulp_i,
	// Clock enables and status
	output logic                        cpu_clk_en_o,
	output logic                        cpu_halt_o,
	output logic                        wake_o,
	output logic                        nmi_o,
	output logic                        sleeping_o,
	output logic      [PR_W-1:0]        per_clk_en_o,
	output logic                        per2x_en_o,
	output logic                        per4x_en_o,
	output logic                        rtc_clk_en_o,
	output logic                        ulp_1k_o,
	output logic                        rc_1k_o,
	// Oscillator control
	output logic      [csc_pkg::NSRC-1:0]  osc_en_o,
	output logic      [csc_pkg::PLL_W-1:0] pll_factor_o,
	output logic      [1:0]             xosc_mode_o,
	output logic      [csc_pkg::CAL_W-1:0] cal32k_o
);
	import csc_pkg::*;

	// ------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------
	logic [SYNC_W-1:0] s1_reg;
	logic [SYNC_W-1:0] s2_reg;
	logic [SYNC_W-1:0] s3_reg;
	logic [SYNC_W-1:0] stab_reg;
	logic [NSRC-1:0]   clk_d_reg;
	logic [NSRC-1:0]   rise;
	logic [NSRC-1:0]   rdy;
	logic [NFAIL-1:0]  fail;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg    <= '0;
			s2_reg    <= '0;
			s3_reg    <= '0;
			stab_reg  <= '0;
			clk_d_reg <= '0;
		end else begin
			s1_reg    <= {osc_fail_i, osc_rdy_i, src_clk_i};
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			// A bit moves only once the last two stages agree
			stab_reg  <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & stab_reg);
			clk_d_reg <= stab_reg[NSRC-1:0];
		end
	end

	assign rise = stab_reg[NSRC-1:0] & ~clk_d_reg;
	assign rdy  = stab_reg[2*NSRC-1:NSRC];
	assign fail = stab_reg[SYNC_W-1:2*NSRC];

	// ------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------
	logic                ack_reg;
	logic [31:0]         dat_reg;
	logic [31:0]         rd_next;
	logic                acc;
	logic                wr;
	logic [7:0]          wd;
	logic [2:0]          cur_reg;
	logic [2:0]          pend_reg;
	logic                pend_v_reg;
	logic [PRESC_W-1:0]  presc_reg;
	logic [NSRC-1:0]     oscen_reg;
	logic [PLL_W-1:0]    pll_reg;
	logic [1:0]          xmode_reg;
	logic [CAL_W-1:0]    cal_reg;
	logic                fm_en_reg;
	logic                fflag_reg;
	logic [2:0]          mode_reg;
	logic                slp_en_reg;
	logic [PR_W-1:0]     pr_reg;
	logic                rtc_en_reg;
	logic                rtc_ulp_reg;
	csc_state_t          st_reg;

	assign acc = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr  = acc && wb_we_i && wb_sel_i[0];
	assign wd  = wb_dat_i[7:0];

	function automatic logic wr_at(input logic w, input logic [7:0] a, input logic [7:0] o);
		wr_at = w && a == o;
	endfunction

	always_comb begin
		rd_next = '0;
		case (wb_adr_i)
			A_SRCSEL:  rd_next[2:0] = cur_reg;
			A_PRESC:   rd_next[PRESC_W-1:0] = presc_reg;
			A_OSCEN:   rd_next[NSRC-1:0] = oscen_reg;
			A_PLL:     rd_next[PLL_W-1:0] = pll_reg;
			A_XOSC:    rd_next[1:0] = xmode_reg;
			A_CAL32K:  rd_next[CAL_W-1:0] = cal_reg;
			A_FAILMON: rd_next[FM_FLAG_B:0] = {fflag_reg, fm_en_reg};
			A_SLEEP:   rd_next[SLP_EN_B:0] = {slp_en_reg, mode_reg};
			A_PR:      rd_next[PR_W-1:0] = pr_reg;
			A_STATUS:  rd_next[ST_PEND_B:0] = {pend_v_reg, st_reg == ST_SLEEP, rdy};
			A_RTC:     rd_next[RTC_ULP_B:0] = {rtc_ulp_reg, rtc_en_reg};
			default:   rd_next = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end else begin
			ack_reg <= acc;
			if (acc && !wb_we_i) begin
				dat_reg <= rd_next;
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// ------------------------------------------------
	// Configuration registers
	// ------------------------------------------------
	logic fail_now;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			presc_reg   <= '0; // [RULE1]
			oscen_reg   <= RST_OSCEN; // [RULE1]
			pll_reg     <= PLL_MIN;
			xmode_reg   <= '0;
			cal_reg     <= RST_CAL;
			fm_en_reg   <= 1'b0;
			mode_reg    <= SLP_IDLE;
			slp_en_reg  <= 1'b0;
			pr_reg      <= '0;
			rtc_en_reg  <= 1'b0;
			rtc_ulp_reg <= 1'b0;
		end else begin
			if (wr_at(wr, wb_adr_i, A_PRESC)) begin
				presc_reg <= wd[PRESC_W-1:0] > PRESC_MAX ? PRESC_MAX : wd[PRESC_W-1:0]; // [RULE2] [RULE7]
			end
			if (wr_at(wr, wb_adr_i, A_OSCEN)) begin
				oscen_reg <= wd[NSRC-1:0];
			end
			// Fallback source must run whatever software wrote
			if (fail_now) begin
				oscen_reg[SRC_RC2M] <= 1'b1; // [RULE3]
			end
			if (wr_at(wr, wb_adr_i, A_PLL)) begin
				pll_reg <= wd[PLL_W-1:0] == '0 ? PLL_MIN : wd[PLL_W-1:0]; // [RULE6]
			end
			if (wr_at(wr, wb_adr_i, A_XOSC)) begin
				xmode_reg <= wd[1:0]; // [RULE9]
			end
			if (wr_at(wr, wb_adr_i, A_CAL32K)) begin
				cal_reg <= wd; // [RULE5]
			end
			if (wr_at(wr, wb_adr_i, A_FAILMON)) begin
				fm_en_reg <= wd[FM_EN_B];
			end
			if (wr_at(wr, wb_adr_i, A_SLEEP)) begin
				mode_reg   <= wd[2:0];
				slp_en_reg <= wd[SLP_EN_B];
			end
			if (wr_at(wr, wb_adr_i, A_PR)) begin
				pr_reg <= wd[PR_W-1:0];
			end
			if (wr_at(wr, wb_adr_i, A_RTC)) begin
				rtc_en_reg  <= wd[RTC_EN_B];
				rtc_ulp_reg <= wd[RTC_ULP_B];
			end
		end
	end

	assign pll_factor_o = pll_reg;
	assign xosc_mode_o  = xmode_reg;
	assign cal32k_o     = cal_reg;

	// ------------------------------------------------
	// Source switching and failure monitor
	// ------------------------------------------------
	logic sw_now;

	assign fail_now = fm_en_reg && ((cur_reg == SRC_XOSC && fail[0]) ||
		(cur_reg == SRC_PLL && fail[1]));
	assign sw_now = !fail_now && pend_v_reg && rdy[pend_reg];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_reg    <= SRC_RC2M; // [RULE1]
			pend_reg   <= SRC_RC2M;
			pend_v_reg <= 1'b0;
			nmi_o      <= 1'b0;
		end else begin
			nmi_o <= fail_now; // [RULE3]
			if (fail_now) begin
				cur_reg    <= SRC_RC2M; // [RULE3]
				pend_v_reg <= 1'b0;
			end else if (sw_now) begin
				cur_reg    <= pend_reg; // [RULE22]
				pend_v_reg <= 1'b0;
			end
			// New request is accepted last so a ready switch never drops it; one written while fail_now holds is dropped
			if (wr_at(wr, wb_adr_i, A_SRCSEL) && !fail_now && wd[2:0] <= SRC_ULP) begin
				pend_reg   <= wd[2:0]; // [RULE2]
				pend_v_reg <= 1'b1;
			end
		end
	end

	// Failure flag: a new failure wins over a write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fflag_reg <= 1'b0;
		end else begin
			fflag_reg <= fail_now ||
				(fflag_reg && !(wr_at(wr, wb_adr_i, A_FAILMON) && wd[FM_FLAG_B])); // [RULE3]
		end
	end

	// ------------------------------------------------
	// Prescaler chain
	// ------------------------------------------------
	csc_presc_if pif ();

	// Enables restart from a clean count, so tick1 fires on the first edge of the new source after a switch
	assign pif.src_tick = rise[cur_reg];
	assign pif.clr      = sw_now || fail_now; // [RULE22]
	assign pif.div_log2 = presc_reg;

	csc_prescaler u_presc (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.p     (pif.div)
	);

	// ------------------------------------------------
	// Low frequency dividers
	// ------------------------------------------------
	logic [LF_W-1:0] ulp_cnt_reg;
	logic [LF_W-1:0] rc_cnt_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ulp_cnt_reg <= '0;
			ulp_1k_o    <= 1'b0;
		end else begin
			ulp_1k_o <= rise[SRC_ULP] && ulp_cnt_reg == LF_LAST; // [RULE4]
			if (rise[SRC_ULP]) begin
				ulp_cnt_reg <= ulp_cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rc_cnt_reg <= '0;
			rc_1k_o    <= 1'b0;
		end else begin
			rc_1k_o <= rise[SRC_RC32K] && rc_cnt_reg == LF_LAST; // [RULE5]
			if (rise[SRC_RC32K]) begin
				rc_cnt_reg <= rc_cnt_reg + 1'b1;
			end
		end
	end

	// ------------------------------------------------
	// Sleep sequencer
	// ------------------------------------------------
	logic [1:0] hcnt_reg;
	logic       wake_ok;

	function automatic logic wake_src(input logic [2:0] m, input logic irq,
		input logic asy, input logic rtc);
		case (m)
			SLP_IDLE:   wake_src = irq; // [RULE16]
			SLP_PSAVE:  wake_src = asy || rtc; // [RULE19]
			SLP_ESTDBY: wake_src = asy || rtc; // [RULE21]
			default:    wake_src = asy; // [RULE18] [RULE20]
		endcase
	endfunction

	assign wake_ok = wake_src(mode_reg, irq_pend_i, twi_match_i || port_async_i,
		rtc_irq_i && rtc_en_reg);

	// Handler order after wake belongs to the interrupt controller and CPU
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg   <= ST_RUN; // [RULE14]
			hcnt_reg <= '0;
			wake_o   <= 1'b0;
		end else begin
			wake_o <= 1'b0;
			case (st_reg)
				ST_RUN: begin
					if (sleep_instr_i && slp_en_reg) begin
						st_reg <= ST_DRAIN;
					end
				end
				ST_DRAIN: begin
					if (!nvm_busy_i) begin
						st_reg <= ST_SLEEP; // [RULE15]
					end
				end
				ST_SLEEP: begin
					if (wake_ok) begin
						st_reg   <= ST_HALT;
						hcnt_reg <= '0;
						wake_o   <= 1'b1; // [RULE11] [RULE12]
					end
				end
				ST_HALT: begin
					if (pif.tick1) begin
						hcnt_reg <= hcnt_reg + 1'b1;
						if (hcnt_reg == HALT_LAST) begin
							st_reg <= ST_RUN; // [RULE13]
						end
					end
				end
				default: st_reg <= ST_RUN;
			endcase
		end
	end

	// ------------------------------------------------
	// Clock gating
	// ------------------------------------------------
	logic asleep;
	logic cpu_run;
	logic per_run;
	logic rtc_run;
	logic osc_keep;
	logic rtc_tick;
	logic [NSRC-1:0] osc_need;

	assign asleep   = st_reg == ST_SLEEP;
	assign cpu_run  = !asleep; // [RULE15]
	assign per_run  = !asleep || mode_reg == SLP_IDLE; // [RULE15] [RULE17]
	assign rtc_run  = !asleep || mode_reg == SLP_IDLE ||
		mode_reg == SLP_PSAVE || mode_reg == SLP_ESTDBY; // [RULE19] [RULE20] [RULE21]
	assign osc_keep = !asleep || mode_reg == SLP_IDLE ||
		mode_reg == SLP_STDBY || mode_reg == SLP_ESTDBY; // [RULE17] [RULE20] [RULE21]
	assign rtc_tick = rtc_ulp_reg ? ulp_1k_o : rc_1k_o;

	always_comb begin
		osc_need = '0;
		osc_need[SRC_ULP]   = wdt_ulp_i || (rtc_en_reg && rtc_ulp_reg && rtc_run); // [RULE4]
		osc_need[SRC_RC32K] = rtc_en_reg && !rtc_ulp_reg && rtc_run;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_clk_en_o <= 1'b0;
			cpu_halt_o   <= 1'b0;
			sleeping_o   <= 1'b0;
			per_clk_en_o <= '0;
			per2x_en_o   <= 1'b0;
			per4x_en_o   <= 1'b0;
			rtc_clk_en_o <= 1'b0;
			osc_en_o     <= RST_OSCEN; // [RULE1]
		end else begin
			cpu_clk_en_o <= pif.tick1 && cpu_run;
			cpu_halt_o   <= st_reg == ST_HALT || asleep; // [RULE13]
			sleeping_o   <= asleep;
			per_clk_en_o <= {PR_W{pif.tick1 && per_run}} & ~pr_reg; // [RULE10]
			per2x_en_o   <= pif.tick2 && per_run; // [RULE8]
			per4x_en_o   <= pif.tick4 && per_run; // [RULE8]
			rtc_clk_en_o <= rtc_tick && rtc_run && rtc_en_reg; // [RULE17] [RULE19]
			osc_en_o     <= (oscen_reg & {NSRC{osc_keep}}) | osc_need; // [RULE4] [RULE20]
		end
	end
endmodule // csc_top

// ---- test/csc_monitor.sv ----
// Port checker for the clock and sleep controller
`timescale 1ns/1ps
module csc_monitor
	import csc_pkg::*;
#(
	parameter int PR_W = 8
) (
	// Clock, reset and bus
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_stb_i,
	input wire logic                      wb_we_i,
	input wire logic [csc_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0]                wb_sel_i,
	input wire logic [31:0]               wb_dat_i,
	input wire logic                      wb_ack_o,
	// Wake and status
	input wire logic                      irq_pend_i,
	input wire logic                      twi_match_i,
	input wire logic                      port_async_i,
	input wire logic                      cpu_clk_en_o,
	input wire logic                      cpu_halt_o,
	input wire logic                      wake_o,
	input wire logic                      nmi_o,
	input wire logic                      sleeping_o,
	input wire logic [PR_W-1:0]           per_clk_en_o,
	input wire logic                      rtc_clk_en_o,
	input wire logic [csc_pkg::NSRC-1:0]  osc_en_o
);
	logic [2:0]      mode_reg;
	logic [PR_W-1:0] pr_reg;
	logic [2:0]      halt_cnt_reg;
	logic            wr_ack;
	assign wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadows lag the design by one edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg <= SLP_IDLE;
			pr_reg   <= '0;
		end else if (wr_ack && wb_adr_i == A_SLEEP) begin
			mode_reg <= wb_dat_i[2:0];
		end else if (wr_ack && wb_adr_i == A_PR) begin
			pr_reg <= wb_dat_i[PR_W-1:0];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || wake_o) begin
			halt_cnt_reg <= '0;
		end else if (cpu_halt_o && cpu_clk_en_o) begin
			halt_cnt_reg <= halt_cnt_reg + 3'h1;
		end
	end
	sequence s_bus_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	property p_ack;
		s_bus_req |=> s_ack_pulse;
	endproperty
	property p_rst;
		$fell(rst_i) |-> osc_en_o == RST_OSCEN && !cpu_halt_o && !sleeping_o;
	endproperty
	property p_nmi;
		nmi_o |-> osc_en_o[SRC_RC2M];
	endproperty
	property p_halt;
		$fell(cpu_halt_o) |-> (halt_cnt_reg + {2'h0, cpu_clk_en_o}) == 3'h4;
	endproperty
	property p_idle_wake;
		sleeping_o && mode_reg == SLP_IDLE && $rose(irq_pend_i) |-> ##[1:3] wake_o;
	endproperty
	property p_pd_nowake;
		sleeping_o && mode_reg == SLP_PDOWN && !twi_match_i && !port_async_i |=> !wake_o;
	endproperty
	property p_pd_quiet;
		sleeping_o && !wake_o && mode_reg == SLP_PDOWN
			|-> !cpu_clk_en_o && !rtc_clk_en_o && per_clk_en_o == '0;
	endproperty
	property p_pr;
		(per_clk_en_o & pr_reg) == '0;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
	a_rst: assert property (p_rst) else $error("wrong state after reset");
	a_nmi: assert property (p_nmi) else $error("nmi without fallback");
	a_halt: assert property (p_halt) else $error("halt length wrong");
	a_idle_wake: assert property (p_idle_wake) else $error("idle no wake");
	a_pd_nowake: assert property (p_pd_nowake) else $error("bad wake");
	a_pd_quiet: assert property (p_pd_quiet) else $error("clock in pdown");
	a_pr: assert property (p_pr) else $error("stopped tick seen");
endmodule // csc_monitor

bind csc_top csc_monitor #(.PR_W(PR_W)) csc_monitor_i (.*);

// ---- test/csc_osc_model.sv ----
// Oscillator pins model: source clocks, ready and failure levels
`timescale 1ns/1ps
module csc_osc_model
	import csc_pkg::*;
(
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// Enables and injected failures
	input  wire logic [csc_pkg::NSRC-1:0]  osc_en_i,
	input  wire logic [csc_pkg::NFAIL-1:0] fail_req_i,
	// Oscillator pins
	output logic      [csc_pkg::NSRC-1:0]  src_clk_o,
	output logic      [csc_pkg::NSRC-1:0]  osc_rdy_o,
	output logic      [csc_pkg::NFAIL-1:0] osc_fail_o
);
	logic [7:0] cnt_reg [NSRC];
	logic [5:0] up_reg  [NSRC];
	// Source i toggles every 8+2i cycles; a failed one stands still
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < NSRC; i++) begin
			if (rst_i || !osc_en_i[i]) begin
				src_clk_o[i] <= 1'b0;
				osc_rdy_o[i] <= 1'b0;
				cnt_reg[i]   <= '0;
				up_reg[i]    <= '0;
			end else begin
				up_reg[i]    <= up_reg[i] + 6'(up_reg[i] != 6'h28);
				osc_rdy_o[i] <= (up_reg[i] == 6'h28);
				if (!(i == 3 && fail_req_i[0]) && !(i == 4 && fail_req_i[1])) begin
					cnt_reg[i] <= (cnt_reg[i] == 8'(7 + 2 * i)) ? 8'h00 : cnt_reg[i] + 8'h01;
					if (cnt_reg[i] == 8'(7 + 2 * i)) src_clk_o[i] <= ~src_clk_o[i];
				end
			end
		end
	end
	always_ff @(posedge clk_i) begin
		osc_fail_o <= rst_i ? '0 : fail_req_i;
	end
endmodule // csc_osc_model

// ---- test/csc_top_test.sv ----
// Self-checking bench for the clock and sleep controller
`timescale 1ns/1ps
module csc_top_test;
	import csc_pkg::*;
	logic             clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sleep_instr_i;
	logic             nvm_busy_i, irq_pend_i, twi_match_i, port_async_i, rtc_irq_i, wdt_ulp_i;
	logic             cpu_clk_en_o, cpu_halt_o, wake_o, nmi_o, sleeping_o, per2x_en_o;
	logic             per4x_en_o, rtc_clk_en_o, ulp_1k_o, rc_1k_o;
	logic [7:0]       wb_adr_i, per_clk_en_o, cal32k_o, acc;
	logic [3:0]       wb_sel_i;
	logic [31:0]      wb_dat_i, wb_dat_o, q, g, c2, c4;
	logic [NSRC-1:0]  src_clk_i, osc_rdy_i, osc_en_o;
	logic [NFAIL-1:0] osc_fail_i, fail_req;
	logic [4:0]       pll_factor_o;
	logic [1:0]       xosc_mode_o;
	logic [6:0]       flg;
	logic [2:0]       md [4];
	int               mismatches, comparisons, n;
	csc_osc_model csc_osc_model_i (.clk_i, .rst_i, .osc_en_i(osc_en_o), .fail_req_i(fail_req),
		.src_clk_o(src_clk_i), .osc_rdy_o(osc_rdy_i), .osc_fail_o(osc_fail_i));
	csc_top #(.PR_W(8)) csc_top_i (.*);
	assign flg = {!cpu_halt_o, nmi_o, wake_o, sleeping_o, rc_1k_o, ulp_1k_o, cpu_clk_en_o};
	// --------------------------------
	// Tasks
	// --------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= 32'(d);
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (k >= 50) check(32'h0, 32'h1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 8'h00);
		check(q, e);
	endtask
	task automatic wait_for(input int w);
		int k;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (flg[w] !== 1'b1 && k < 4000);
		if (k >= 4000) check(32'(w), 32'hffff);
	endtask
	task automatic gap(input int w);
		wait_for(w);
		{g, c2, c4} = '0;
		do begin
			@(posedge clk_i);
			g++;
			c2 += 32'(per2x_en_o);
			c4 += 32'(per4x_en_o);
		end while (flg[w] !== 1'b1 && g < 4000);
	endtask
	task automatic go_sleep(input logic [2:0] m);
		wr(A_SLEEP, {4'h0, 1'b1, m});
		@(posedge clk_i);
		sleep_instr_i <= 1'b1;
		@(posedge clk_i);
		sleep_instr_i <= 1'b0;
	endtask
	task automatic end_of_test;
		if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// --------------------------------
	// Clock, watchdog, tests
	// --------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		mismatches++;
		end_of_test;
	end
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, sleep_instr_i, nvm_busy_i, irq_pend_i} = '0;
		{twi_match_i, port_async_i, rtc_irq_i, wdt_ulp_i, wb_adr_i, wb_dat_i} = '0;
		{mismatches, comparisons, fail_req} = '0;
		md = '{SLP_PDOWN, SLP_PSAVE, SLP_STDBY, SLP_ESTDBY};
		wb_sel_i = 4'h1;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(A_SRCSEL, 32'h0);
		rd(A_OSCEN, 32'h1);
		check(32'(osc_en_o), 32'h1);
		rd(A_CAL32K, 32'h80);
		rd(8'h3c, 32'h0);
		wr(A_PLL, 8'h00);
		rd(A_PLL, 32'h1);
		wr(A_PLL, 8'h1f);
		check(32'(pll_factor_o), 32'h1f);
		for (int m = 0; m < 4; m++) begin
			wr(A_XOSC, 8'(m));
			check(32'(xosc_mode_o), 32'(m));
		end
		wr(A_CAL32K, 8'h5a);
		check(32'(cal32k_o), 32'h5a);
		wdt_ulp_i <= 1'b1;
		gap(1);
		check(g, 32'h0480);
		check(32'(osc_en_o[SRC_ULP]), 32'h1);
		wdt_ulp_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		check(32'(osc_en_o[SRC_ULP]), 32'h0);
		wr(A_OSCEN, 8'h05);
		gap(2);
		check(g, 32'h0300);
		wr(A_PRESC, 8'h0f);
		rd(A_PRESC, 32'hb);
		for (int k = 2; k < 4; k++) begin
			wr(A_PRESC, 8'(k));
			gap(0);
			gap(0);
			check(g, 32'(16 << k));
			check(c2, 32'h2);
			check(c4, 32'h4);
		end
		wr(A_OSCEN, 8'h0d);
		wr(A_SRCSEL, {5'h00, SRC_XOSC});
		xfer(1'b0, A_STATUS, 8'h00);
		check(32'(q[ST_PEND_B]), 32'h1);
		rd(A_SRCSEL, 32'h0);
		repeat (100) @(posedge clk_i);
		rd(A_SRCSEL, 32'h3);
		gap(0);
		gap(0);
		check(g, 32'he0);
		wr(A_FAILMON, 8'h01);
		fail_req <= 2'b01;
		wait_for(5);
		rd(A_SRCSEL, 32'h0);
		rd(A_FAILMON, 32'h3);
		fail_req <= 2'b00;
		wr(A_FAILMON, 8'h03);
		rd(A_FAILMON, 32'h1);
		wr(A_PRESC, 8'h00);
		wr(A_PR, 8'h05);
		acc = '0;
		repeat (300) begin
			@(posedge clk_i);
			acc |= per_clk_en_o;
		end
		check(32'(acc), 32'hfa);
		wr(A_PR, 8'h00);
		nvm_busy_i <= 1'b1;
		go_sleep(SLP_IDLE);
		repeat (20) @(posedge clk_i);
		check(32'(sleeping_o), 32'h0);
		nvm_busy_i <= 1'b0;
		wait_for(3);
		irq_pend_i <= 1'b1;
		wait_for(4);
		{n, g} = '0;
		do begin
			@(posedge clk_i);
			g++;
			n += int'(cpu_clk_en_o);
		end while (cpu_halt_o !== 1'b0 && g < 2000);
		check(32'(n), 32'h4);
		irq_pend_i <= 1'b0;
		wr(A_RTC, 8'h01);
		for (int i = 0; i < 4; i++) begin
			go_sleep(md[i]);
			wait_for(3);
			repeat (2) @(posedge clk_i);
			check(32'(osc_en_o[SRC_XOSC]), 32'(i >= 2));
			irq_pend_i <= 1'b1;
			rtc_irq_i  <= 1'b1;
			repeat (40) @(posedge clk_i);
			check(32'(sleeping_o), 32'(i % 2 == 0));
			port_async_i <= 1'b1;
			wait_for(6);
			{irq_pend_i, rtc_irq_i, port_async_i} <= 3'h0;
		end
		end_of_test;
	end
endmodule // csc_top_test
